/* File: hw/chan_reg_regs.svh */
// Constants of the channel-indexed register bank: offsets, fields, defaults.
// Assumes a 13-bit register address taken from a 16-bit serial instruction.
//
// Operation
// - Decode config, index/transfer and global address regions
// - Lane select low resets to 0x3F
// - Local registers keep one copy per lane
// - Local write updates every selected lane copy
// - All selected on read returns first lane copy
// - Global registers single copy, index ignored
// - Port config reads three-wire, 16-bit addressing
// - Soft reset bit restores defaults, self-clears
// - Frame is 16-bit instruction then counted bytes, or streamed bytes until select rises for length code 3
// - Sample on rising, drive on falling edge
`ifndef CHAN_REG_REGS_SVH
`define CHAN_REG_REGS_SVH

`define ADDR_W 13
`define LANES 10
`define DATA_LANES 8
`define INSTR_BITS 16

// Register offsets
`define REG_CFG 13'h0000
`define REG_CHIP_ID 13'h0001
`define REG_GRADE 13'h0002
`define REG_IDX2 13'h0004
`define REG_IDX1 13'h0005
`define REG_TEST 13'h000D
`define REG_XFER 13'h00FF
`define REG_PWR 13'h0008
`define REG_CLK 13'h0009

// Field positions and masks
`define CFG_SOFT_RST 5
`define CFG_LSB_HI 6
`define CFG_LSB_LO 1
`define IDX2_MASK 8'h0F
`define IDX1_MASK 8'h3F
`define XFER_MASK 8'h01
`define PWR_MASK 8'h23
`define CLK_MASK 8'h01

// Reset values
`define IDX2_RST 8'h0F
`define IDX1_RST 8'h3F
`define XFER_RST 8'h00
`define PWR_RST 8'h00
`define CLK_RST 8'h01
`define TEST_RST 8'h00
`define STREAM_LEN 2'h3

`endif

/* File: hw/chan_reg_pkg.sv */
// Types shared by the register bank and its testbench.
// Assumes chan_reg_regs.svh supplies the numeric constants.
package chan_reg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum {ST_INSTR, ST_WDATA, ST_RDATA, ST_DONE} frame_state_t;
endpackage : chan_reg_pkg

/* File: hw/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to i_mclk; output moves when stages 2 and 3 agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RST = 1'b0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Pin and clean level
  input wire logic i_pin,
  output logic o_level
);
  logic meta_ff, mid_ff, late_ff, level_ff;
  logic nxt_level;

  ////////////////////////////////////////////////////////////////////////////
  // Level follows only once two settled stages agree, filtering single glitches
  always_comb begin
    nxt_level = level_ff;
    if (mid_ff == late_ff) begin
      nxt_level = late_ff;
    end
  end

  // Meta stage feeds only the mid stage
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= RST;
      mid_ff <= RST;
      late_ff <= RST;
      level_ff <= RST;
    end else begin
      meta_ff <= i_pin;
      mid_ff <= meta_ff;
      late_ff <= mid_ff;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;
endmodule : pin_sync

/* File: hw/chan_reg_bank.sv */
// Serial-port register bank with per-lane local copies steered by two index registers.
// Assumes serial clock well below i_mclk/8 and a host that keeps the frame rules.
`timescale 1ns/1ns
`include "chan_reg_regs.svh"
module chan_reg_bank #(
  parameter chan_reg_pkg::byte_t CHIP_ID = 8'h5A, // Arbitrary identification value
  parameter chan_reg_pkg::byte_t GRADE = 8'h10    // Arbitrary grade value
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Serial port pins
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  // Register-driven controls
  output logic o_lsb_first,
  output logic [1:0] o_power_mode,
  output logic o_pdwn_standby,
  output logic o_duty_cycle_stabilizer,
  output logic o_transfer,
  output logic [`LANES*8-1:0] o_lane_test_mode
);
  import chan_reg_pkg::*;

  // Region check for the one local register
  function automatic logic is_local(input logic [`ADDR_W-1:0] a);
    return a == `REG_TEST;
  endfunction : is_local

  // Lowest selected data lane; none selected falls back to lane 0
  function automatic logic [3:0] low_lane(input logic [`DATA_LANES-1:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `DATA_LANES - 1; i >= 0; i--) begin
      if (s[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : low_lane

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: sclk idles low, csb idles high
  localparam logic [2:0] SYNC_RST = 3'h2;
  logic [2:0] pins_raw, pins_s;
  assign pins_raw = {i_sdio, i_csb_n, i_sclk};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      pin_sync #(.RST(SYNC_RST[g])) u_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_pin(pins_raw[g]),
        .o_level(pins_s[g])
      );
    end
  endgenerate

  logic sclk_s, csb_s, sdio_s, sclk_d_ff, sclk_rise, sclk_fall;
  assign sclk_s = pins_s[0];
  assign csb_s = pins_s[1];
  assign sdio_s = pins_s[2];
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic lsb_ff, nxt_lsb;
  byte_t idx1_ff, nxt_idx1, idx2_ff, nxt_idx2, xfer_ff, nxt_xfer;
  byte_t pwr_ff, nxt_pwr, clk_ff, nxt_clk;
  byte_t lane_ff [`LANES];
  byte_t nxt_lane [`LANES];
  logic [`LANES-1:0] sel;
  byte_t cfg_rd, rd_val, rd_local;
  logic [`ADDR_W-1:0] rd_addr;

  // Select order: A..D, E..H data lanes, then frame clock, bit clock lanes
  assign sel = {idx1_ff[5], idx1_ff[4], idx2_ff[3:0], idx1_ff[3:0]};
  // Fixed three-wire, 16-bit address bits, nibble-mirrored bit order flag
  assign cfg_rd = {1'b0, lsb_ff, 1'b0, 1'b1, 1'b1, 1'b0, lsb_ff, 1'b0};
  // All-selected and partial both resolve to the lowest data lane
  assign rd_local = lane_ff[low_lane(sel[`DATA_LANES-1:0])];

  // Read mux; unknown addresses return zero with no side effect
  always_comb begin
    rd_val = 8'h00;
    case (rd_addr)
      `REG_CFG: rd_val = cfg_rd;
      `REG_CHIP_ID: rd_val = CHIP_ID;
      `REG_GRADE: rd_val = GRADE;
      `REG_IDX2: rd_val = idx2_ff;
      `REG_IDX1: rd_val = idx1_ff;
      `REG_XFER: rd_val = xfer_ff;
      `REG_PWR: rd_val = pwr_ff;
      `REG_CLK: rd_val = clk_ff;
      default: rd_val = is_local(rd_addr) ? rd_local : 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine
  frame_state_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [14:0] instr_ff, nxt_instr;
  logic [15:0] instr_full;
  logic [`ADDR_W-1:0] addr_ff, nxt_addr;
  logic [1:0] wlen_ff, nxt_wlen, bytes_ff, nxt_bytes;
  byte_t shift_ff, nxt_shift;
  logic out_ff, nxt_out, oe_ff, nxt_oe;
  logic wr_en;
  logic [`ADDR_W-1:0] wr_addr;
  byte_t wr_data;
  logic last_byte;

  assign instr_full = {instr_ff, sdio_s};
  assign rd_addr = (st_ff == ST_INSTR) ? instr_full[`ADDR_W-1:0] : addr_ff - 13'h0001;
  assign last_byte = (wlen_ff != `STREAM_LEN) && (bytes_ff == wlen_ff);

  // Bits enter on sclk rise, read bits leave on sclk fall; address steps down per byte
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_instr = instr_ff;
    nxt_addr = addr_ff;
    nxt_wlen = wlen_ff;
    nxt_bytes = bytes_ff;
    nxt_shift = shift_ff;
    nxt_out = out_ff;
    nxt_oe = oe_ff;
    wr_en = 1'b0;
    wr_addr = addr_ff;
    wr_data = {shift_ff[6:0], sdio_s};
    if (csb_s) begin
      nxt_st = ST_INSTR;
      nxt_cnt = 4'h0;
      nxt_oe = 1'b0;
    end else if (sclk_rise) begin
      case (st_ff)
        ST_INSTR: begin
          nxt_instr = instr_full[14:0];
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'hF) begin
            nxt_addr = instr_full[`ADDR_W-1:0];
            nxt_wlen = instr_full[14:13];
            nxt_bytes = 2'h0;
            nxt_cnt = 4'h0;
            if (instr_full[15]) begin
              nxt_st = ST_RDATA;
              nxt_oe = 1'b1;
              nxt_shift = rd_val;
            end else begin
              nxt_st = ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          nxt_shift = wr_data;
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'h7) begin
            wr_en = 1'b1;
            nxt_cnt = 4'h0;
            nxt_addr = addr_ff - 13'h0001;
            nxt_bytes = bytes_ff + 2'h1;
            if (last_byte) begin
              nxt_st = ST_DONE;
            end
          end
        end
        ST_RDATA: begin
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'h7) begin
            nxt_cnt = 4'h0;
            nxt_addr = addr_ff - 13'h0001;
            nxt_bytes = bytes_ff + 2'h1;
            nxt_shift = rd_val;
            if (last_byte) begin
              nxt_st = ST_DONE;
            end
          end
        end
        default: nxt_st = st_ff;
      endcase
    end else if (sclk_fall && st_ff == ST_RDATA) begin
      nxt_out = shift_ff[7];
      nxt_shift = {shift_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= ST_INSTR;
      cnt_ff <= 4'h0;
      instr_ff <= 15'h0000;
      addr_ff <= 13'h0000;
      wlen_ff <= 2'h0;
      bytes_ff <= 2'h0;
      shift_ff <= 8'h00;
      out_ff <= 1'b0;
      oe_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      instr_ff <= nxt_instr;
      addr_ff <= nxt_addr;
      wlen_ff <= nxt_wlen;
      bytes_ff <= nxt_bytes;
      shift_ff <= nxt_shift;
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
      sclk_d_ff <= sclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; soft reset reloads every default; its own bit is not stored, so it reads back clear
  always_comb begin
    nxt_lsb = lsb_ff;
    nxt_idx1 = idx1_ff;
    nxt_idx2 = idx2_ff;
    nxt_xfer = xfer_ff;
    nxt_pwr = pwr_ff;
    nxt_clk = clk_ff;
    for (int k = 0; k < `LANES; k++) begin
      nxt_lane[k] = lane_ff[k];
    end
    if (wr_en) begin
      case (wr_addr)
        `REG_CFG: begin
          if (wr_data[`CFG_SOFT_RST]) begin
            nxt_lsb = 1'b0;
            nxt_idx1 = `IDX1_RST;
            nxt_idx2 = `IDX2_RST;
            nxt_xfer = `XFER_RST;
            nxt_pwr = `PWR_RST;
            nxt_clk = `CLK_RST;
            for (int k = 0; k < `LANES; k++) begin
              nxt_lane[k] = `TEST_RST;
            end
          end else begin
            nxt_lsb = wr_data[`CFG_LSB_HI] | wr_data[`CFG_LSB_LO];
          end
        end
        `REG_IDX2: nxt_idx2 = wr_data & `IDX2_MASK;
        `REG_IDX1: nxt_idx1 = wr_data & `IDX1_MASK;
        `REG_XFER: nxt_xfer = wr_data & `XFER_MASK;
        `REG_PWR: nxt_pwr = wr_data & `PWR_MASK;
        `REG_CLK: nxt_clk = wr_data & `CLK_MASK;
        default: begin
          if (is_local(wr_addr)) begin
            for (int k = 0; k < `LANES; k++) begin
              if (sel[k]) begin
                nxt_lane[k] = wr_data;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lsb_ff <= 1'b0;
      idx1_ff <= `IDX1_RST;
      idx2_ff <= `IDX2_RST;
      xfer_ff <= `XFER_RST;
      pwr_ff <= `PWR_RST;
      clk_ff <= `CLK_RST;
      for (int k = 0; k < `LANES; k++) begin
        lane_ff[k] <= `TEST_RST;
      end
    end else begin
      lsb_ff <= nxt_lsb;
      idx1_ff <= nxt_idx1;
      idx2_ff <= nxt_idx2;
      xfer_ff <= nxt_xfer;
      pwr_ff <= nxt_pwr;
      clk_ff <= nxt_clk;
      for (int k = 0; k < `LANES; k++) begin
        lane_ff[k] <= nxt_lane[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_sdio = out_ff;
  assign o_sdio_oe = oe_ff;
  assign o_lsb_first = lsb_ff;
  assign o_power_mode = pwr_ff[1:0];
  assign o_pdwn_standby = pwr_ff[5];
  assign o_duty_cycle_stabilizer = clk_ff[0];
  assign o_transfer = xfer_ff[0];
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane_out
      assign o_lane_test_mode[g*8 +: 8] = lane_ff[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  AST_SOFT_RESET: assert property (wr_en && wr_addr == `REG_CFG && wr_data[5] |=>
    idx1_ff == 8'h3F && idx2_ff == 8'h0F && clk_ff == 8'h01 && cfg_rd == 8'h18)
    else $error("soft reset did not restore defaults");
  AST_IDX1_DEFAULT: assert property (wr_en && wr_addr == `REG_CFG && wr_data[5] |=>
    idx1_ff[7:6] == 2'h0 && idx1_ff[5:0] == 6'h3F && sel == 10'h3FF)
    else $error("lane select low default wrong");
  // Checked through the read mux so a misrouted config read is caught too
  AST_CFG_FIXED: assert property (rd_addr == `REG_CFG |-> rd_val[0] == 1'b0 &&
    rd_val[7] == 1'b0 && rd_val[4:3] == 2'h3 && rd_val[5] == 1'b0 && rd_val[2] == 1'b0)
    else $error("port config fixed bits wrong");
  AST_LOCAL_WRITE: assert property (wr_en && is_local(wr_addr) && sel[0] |=>
    lane_ff[0] == $past(wr_data))
    else $error("selected lane copy not written");
  AST_LOCAL_KEEP: assert property (wr_en && is_local(wr_addr) && !sel[9] |=>
    $stable(lane_ff[9]))
    else $error("unselected lane copy changed");
  AST_READ_ALL: assert property (sel[7:0] == 8'hFF |-> rd_local == lane_ff[0])
    else $error("all-select read not lane zero");
  AST_READ_LOW: assert property (sel[1:0] == 2'h2 |-> rd_local == lane_ff[1])
    else $error("partial read not lowest lane");
  AST_GLOBAL: assert property (wr_en && wr_addr == `REG_CLK |=>
    clk_ff[0] == $past(wr_data[0]) && $stable(lane_ff[0]))
    else $error("global write misrouted");
  AST_UNMAPPED: assert property (wr_en && wr_addr == 13'h0013 |=>
    $stable(idx1_ff) && $stable(idx2_ff) && $stable(clk_ff) && $stable(lane_ff[0]))
    else $error("unmapped write changed state");
  AST_UNMAPPED_RD: assert property (rd_addr == 13'h0003 |-> rd_val == 8'h00)
    else $error("unmapped read not zero");
  AST_TURN: assert property (!csb_s && sclk_rise && st_ff == ST_INSTR &&
    cnt_ff == 4'hF && instr_full[15] |=> o_sdio_oe && st_ff == ST_RDATA)
    else $error("sdio did not turn around");
  AST_DRIVE_FALL: assert property ($changed(o_sdio) |-> $past(sclk_fall))
    else $error("sdio changed off falling edge");
  AST_WRITE_COUNT: assert property (sclk_rise && st_ff == ST_WDATA && cnt_ff == 4'h7 &&
    !csb_s && wlen_ff == 2'h0 |=> st_ff == ST_DONE)
    else $error("single byte write did not end");

  COV_LOCAL_ALL: cover property (wr_en && is_local(wr_addr) && sel == 10'h3FF);
  COV_SOFT_RESET: cover property (wr_en && wr_addr == `REG_CFG && wr_data[5]);
  COV_READ: cover property (st_ff == ST_RDATA && o_sdio_oe);
  COV_STREAM: cover property (wlen_ff == 2'h3 && bytes_ff == 2'h3);
endmodule : chan_reg_bank

/* File: verif/serial_host_model.sv */
// Behavioural serial host that drives the clock, select and data pins of the bank.
// Assumes the tb resolves the shared data line from both parties' drive.
`timescale 1ns/1ns
module serial_host_model (
  // Clock used only to pace the pin edges
  input wire logic i_mclk,
  // Resolved data line and the device's drive enable
  input wire logic i_line,
  input wire logic i_dev_oe,
  // Host pins
  output logic o_sclk,
  output logic o_csb_n,
  output logic o_sdio
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle pins: clock stands still low outside frames, select high
  initial begin
    o_sclk = 1'b0;
    o_csb_n = 1'b1;
    o_sdio = 1'b0;
  end

  // Half serial period of 8 mclk leaves margin over the 5-cycle phase minimum
  task automatic half();
    repeat (8) @(negedge i_mclk);
  endtask : half

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: instruction, then nb bytes MSB first; oe_ok drops if the device let go
  task automatic frame(input logic rd, input logic [12:0] addr, input int nb,
                       input logic [31:0] wdat, output logic [31:0] rdat, output logic oe_ok);
    logic [15:0] instr;
    int i;
    instr = {rd, 2'(nb - 1), addr};
    rdat = '0;
    oe_ok = 1'b1;
    @(negedge i_mclk);
    o_csb_n = 1'b0;
    half();
    for (i = 15; i >= 0; i--) begin
      o_sdio = instr[i]; // Changed while clock low, held past the rise
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    for (i = 8 * nb - 1; i >= 0; i--) begin
      // Released line toggles so a stale value never passes for data
      o_sdio = rd ? ~o_sdio : wdat[i];
      half();
      if (rd) begin
        rdat[i] = i_line; // Sampled just before the rise
        oe_ok = oe_ok & i_dev_oe;
      end
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    o_csb_n = 1'b1;
    o_sdio = ~o_sdio;
    repeat (8) @(negedge i_mclk);
  endtask : frame
endmodule : serial_host_model

/* File: verif/tb.sv */
// Self-checking bench for the channel-indexed register bank.
// Assumes the host model paces frames; all checks are made on settled outputs.
`timescale 1ns/1ns
`include "chan_reg_regs.svh"
module tb;
  import chan_reg_pkg::*;
  localparam byte_t ID_EXP = 8'h5A; // Arbitrary identification value
  localparam byte_t GRADE_EXP = 8'h10; // Arbitrary grade value
  logic i_mclk, i_arst_n, sclk, csb_n, host_sdio, dev_sdio, dev_oe, line;
  logic lsb_first, standby, duty_cycle_stabilizer, xfer;
  logic [1:0] pwr;
  logic [79:0] lanes;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  assign line = dev_oe ? dev_sdio : host_sdio;

  chan_reg_bank #(.CHIP_ID(ID_EXP), .GRADE(GRADE_EXP)) dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_csb_n(csb_n), .i_sdio(line),
    .o_sdio(dev_sdio), .o_sdio_oe(dev_oe), .o_lsb_first(lsb_first), .o_power_mode(pwr),
    .o_pdwn_standby(standby), .o_duty_cycle_stabilizer(duty_cycle_stabilizer), .o_transfer(xfer),
    .o_lane_test_mode(lanes));

  serial_host_model host (.i_mclk(i_mclk), .i_line(line), .i_dev_oe(dev_oe),
    .o_sclk(sclk), .o_csb_n(csb_n), .o_sdio(host_sdio));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the roughly 17k cycles the run needs
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input byte_t d);
    logic [31:0] r;
    logic ok;
    host.frame(1'b0, a, 1, {24'h0, d}, r, ok);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [12:0] a, input byte_t exp);
    logic [31:0] r;
    logic ok;
    host.frame(1'b1, a, 1, 32'h0, r, ok);
    chk(nm, r[7:0], exp);
    chk("read drive enable", ok, 1'b1);
    chk("drive released", dev_oe, 1'b0);
  endtask : rd_chk

  task automatic sel(input byte_t hi, input byte_t lo);
    wr(`REG_IDX2, hi); // Unsupported bits kept zero
    wr(`REG_IDX1, lo);
  endtask : sel

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults();
    chk("pins after reset", {lsb_first, pwr, standby, duty_cycle_stabilizer, xfer}, 6'h02);
    chk("lane copies reset", lanes, 80'h0);
    rd_chk("port config", `REG_CFG, 8'h18);
    rd_chk("chip id", `REG_CHIP_ID, ID_EXP);
    rd_chk("grade", `REG_GRADE, GRADE_EXP);
    rd_chk("index high", `REG_IDX2, 8'h0F);
    rd_chk("index low", `REG_IDX1, 8'h3F);
    rd_chk("power", `REG_PWR, 8'h00);
    rd_chk("clock", `REG_CLK, 8'h01);
    rd_chk("transfer", `REG_XFER, 8'h00);
  endtask : t_defaults

  task automatic t_lanes();
    logic [79:0] exp;
    exp = {10{8'h11}};
    wr(`REG_TEST, 8'h11);
    chk("all lanes write", lanes, exp);
    sel(8'h00, 8'h04);
    wr(`REG_TEST, 8'h22);
    exp[23:16] = 8'h22;
    chk("single lane write", lanes, exp);
    sel(8'h08, 8'h10);
    wr(`REG_TEST, 8'h33);
    exp[63:56] = 8'h33;
    exp[71:64] = 8'h33;
    chk("split index write", lanes, exp);
    sel(8'h00, 8'h04); // One data lane before a local read
    rd_chk("one lane read", `REG_TEST, 8'h22);
    sel(8'h0F, 8'h3F);
    rd_chk("all selected read", `REG_TEST, 8'h11);
    sel(8'h08, 8'h0C);
    rd_chk("partial read", `REG_TEST, 8'h22);
    chk("lanes untouched by reads", lanes, exp);
  endtask : t_lanes

  task automatic t_global();
    logic [31:0] r;
    logic ok;
    sel(8'h00, 8'h01);
    host.frame(1'b0, `REG_CLK, 2, {16'h0, 8'h00, 8'h22}, r, ok); // Address walks down
    chk("stream clock", duty_cycle_stabilizer, 1'b0);
    chk("stream power", {standby, pwr}, 3'b110);
    wr(`REG_XFER, 8'h01);
    chk("transfer pin", xfer, 1'b1);
    sel(8'h02, 8'h20);
    // Streaming read walks 0x05 down to 0x02 until select rises
    host.frame(1'b1, `REG_IDX1, 4, 32'h0, r, ok);
    chk("stream read", r, {8'h20, 8'h02, 8'h00, GRADE_EXP});
    chk("stream drive enable", ok, 1'b1);
    rd_chk("power other index", `REG_PWR, 8'h22);
    rd_chk("transfer other index", `REG_XFER, 8'h01);
    rd_chk("open address 03", 13'h0003, 8'h00);
    rd_chk("open address 13", 13'h0013, 8'h00);
  endtask : t_global

  task automatic t_soft_reset();
    wr(`REG_CFG, 8'h5A);
    chk("bit order flag", lsb_first, 1'b1);
    wr(`REG_CFG, 8'h3C);
    chk("pins after soft reset", {lsb_first, pwr, standby, duty_cycle_stabilizer, xfer}, 6'h02);
    chk("lanes after soft reset", lanes, 80'h0);
    rd_chk("config self clears", `REG_CFG, 8'h18);
    rd_chk("index after soft reset", `REG_IDX1, 8'h3F);
    rd_chk("index2 after soft reset", `REG_IDX2, 8'h0F);
  endtask : t_soft_reset

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict, the single end of the run
  task automatic give_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Main sequence: two-cycle reset, then the scenarios in order
  initial begin
    i_arst_n = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    t_defaults();
    t_lanes();
    t_global();
    t_soft_reset();
    give_verdict();
  end
endmodule : tb
